// >>> src/bmrf_defs.vh
`ifndef BMRF_DEFS_VH
`define BMRF_DEFS_VH

// ****************************************************************
// Mode encodings (five-bit mode field of the status word)
// ****************************************************************
`define BMRF_MODE_USER 5'h10
`define BMRF_MODE_FAST 5'h11
`define BMRF_MODE_IRQ 5'h12
`define BMRF_MODE_SUPV 5'h13
`define BMRF_MODE_ABORT 5'h17
`define BMRF_MODE_UNDEF 5'h1b
`define BMRF_MODE_SYS 5'h1f

// ****************************************************************
// Status word field positions
// ****************************************************************
`define BMRF_SW_MODE_LO 0
`define BMRF_SW_MODE_HI 4
`define BMRF_SW_STATE_BIT 5
`define BMRF_SW_FIQ_DIS_BIT 6
`define BMRF_SW_IRQ_DIS_BIT 7
`define BMRF_SW_FLAGS_LO 28
`define BMRF_SW_RESET 32'h000000d3

// ****************************************************************
// Physical register indices (31 general copies)
// ****************************************************************
`define BMRF_NUM_PHYS 31
`define BMRF_PHYS_PC 5'h0f
`define BMRF_PHYS_FAST_BASE 5'h10
`define BMRF_PHYS_SUPV_SP 5'h17
`define BMRF_PHYS_ABORT_SP 5'h19
`define BMRF_PHYS_UNDEF_SP 5'h1b
`define BMRF_PHYS_IRQ_SP 5'h1d
`define BMRF_PHYS_FAST_SP 5'h15
`define BMRF_PC_RESET 32'h00000000

// ****************************************************************
// Saved status word bank indices
// ****************************************************************
`define BMRF_SAVED_FAST 3'h0
`define BMRF_SAVED_IRQ 3'h1
`define BMRF_SAVED_SUPV 3'h2
`define BMRF_SAVED_ABORT 3'h3
`define BMRF_SAVED_UNDEF 3'h4
`define BMRF_SAVED_NONE 3'h7

// ****************************************************************
// Transfer sizes
// ****************************************************************
`define BMRF_SIZE_BYTE 2'h0
`define BMRF_SIZE_HALF 2'h1
`define BMRF_SIZE_WORD 2'h2

`endif

// >>> src/bmrf_phys_mem.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Physical register array, one write port, two registered reads
// ****************************************************************
module bmrf_phys_mem #(
	parameter WIDTH = 32,
	parameter DEPTH = 31,
	parameter AW = 5
) (
	input wire clk,
	input wire rst,
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [WIDTH-1:0] wdata,
	input wire [AW-1:0] raddr_a,
	input wire [AW-1:0] raddr_b,
	output reg [WIDTH-1:0] rdata_a,
	output reg [WIDTH-1:0] rdata_b
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	integer i;

	always @(posedge clk) begin
		if (rst) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem[i] <= {WIDTH{1'b0}};
			end
			rdata_a <= {WIDTH{1'b0}};
			rdata_b <= {WIDTH{1'b0}};
		end else begin
			if (we) begin
				mem[waddr] <= wdata;
			end
			rdata_a <= (we && waddr == raddr_a) ? wdata : mem[raddr_a];
			rdata_b <= (we && waddr == raddr_b) ? wdata : mem[raddr_b];
		end
	end
endmodule // bmrf_phys_mem

`default_nettype wire

// >>> src/bmrf_bank_map.v
`timescale 1ns/1ps
`default_nettype none
`include "bmrf_defs.vh"

// ****************************************************************
// Register number to physical index for a given mode
// ****************************************************************
module bmrf_bank_map (
	input wire [4:0] mode,
	input wire [3:0] regnum,
	output reg [4:0] phys
);
	always @* begin
		// (RL3) Low numbers shared
		phys = {1'b0, regnum};
		if (regnum >= 4'h8 && regnum <= 4'hc && mode == `BMRF_MODE_FAST) begin
			// (RL12) Private fast copies
			phys = `BMRF_PHYS_FAST_BASE + {2'h0, regnum[2:0]};
		end else if (regnum == 4'hd || regnum == 4'he) begin
			// (RL4) Banked by mode
			case (mode)
				`BMRF_MODE_FAST: phys = `BMRF_PHYS_FAST_SP + {4'h0, ~regnum[0]};
				`BMRF_MODE_SUPV: phys = `BMRF_PHYS_SUPV_SP + {4'h0, ~regnum[0]};
				`BMRF_MODE_ABORT: phys = `BMRF_PHYS_ABORT_SP + {4'h0, ~regnum[0]};
				`BMRF_MODE_UNDEF: phys = `BMRF_PHYS_UNDEF_SP + {4'h0, ~regnum[0]};
				`BMRF_MODE_IRQ: phys = `BMRF_PHYS_IRQ_SP + {4'h0, ~regnum[0]};
				// (RL14) System uses user copies
				default: phys = {1'b0, regnum};
			endcase
		end
	end
endmodule // bmrf_bank_map

`default_nettype wire

// >>> src/bmrf_top.v
// Behaviour
// (RL1) 31 general 32-bit copies plus six status words in total.
// (RL2) Sixteen register numbers visible; mode picks their physical copies.
// (RL3) Numbers 0 to 7 share one physical copy in every mode.
// (RL4) Numbers 8 to 14 are banked by current mode.
// (RL5) Number 15 is the program counter, readable by every instruction.
// (RL6) Call with link leaves the return address in the current link register.
// (RL7) Seven modes: user, fast, irq, supervisor, abort, system, undefined.
// (RL8) Mode changes by software, external interrupt or exception entry.
// (RL9) Instructions are 32 bits wide or 16 bits in compact state.
// (RL10) Byte, half-word and word transfer sizes.
// (RL11) Software keeps words four-byte and halves two-byte aligned.
// (RL12) Fast mode has private copies of numbers 8 to 12.
// (RL13) Each exception mode has private stack pointer and link register.
// (RL14) System mode uses exactly the user mode copies.
// (RL15) Five saved status words capture the current status on exception entry.
// (RL16) Ports resolve from current mode same cycle; writes hit active copy only.
`timescale 1ns/1ps
`default_nettype none
`include "bmrf_defs.vh"

module bmrf_top #(
	parameter WIDTH = 32
) (
	input wire clk,
	input wire rst,
	input wire [3:0] rd_num_a,
	input wire [3:0] rd_num_b,
	input wire wr_en,
	input wire [3:0] wr_num,
	input wire [WIDTH-1:0] wr_data,
	input wire [1:0] wr_size,
	input wire link_en,
	input wire pc_adv,
	input wire [WIDTH-1:0] pc_load,
	input wire pc_load_en,
	input wire exc_en,
	input wire [4:0] exc_mode,
	input wire [WIDTH-1:0] exc_vector,
	input wire [WIDTH-1:0] exc_return,
	input wire sw_wr_en,
	input wire [WIDTH-1:0] sw_wr_data,
	input wire saved_wr_en,
	input wire [WIDTH-1:0] saved_wr_data,
	input wire ret_restore,
	output reg [WIDTH-1:0] rd_data_a,
	output reg [WIDTH-1:0] rd_data_b,
	output reg [WIDTH-1:0] pc_out,
	output reg [WIDTH-1:0] current_status_word,
	output reg [WIDTH-1:0] saved_status_word,
	output reg [4:0] mode_out,
	output reg privileged,
	output reg mode_bad
);
	// ****************************************************************
	// Local state
	// ****************************************************************
	reg [WIDTH-1:0] pc_r;
	reg [WIDTH-1:0] pc_nxt;
	reg [WIDTH-1:0] cur_sw_r;
	reg [WIDTH-1:0] cur_sw_nxt;
	reg [WIDTH-1:0] saved_r [0:4];
	wire [4:0] mode;
	wire [4:0] phys_a;
	wire [4:0] phys_b;
	wire [4:0] phys_w;
	wire [4:0] phys_lr;
	wire [4:0] phys_lr_exc;
	wire [WIDTH-1:0] mem_a;
	wire [WIDTH-1:0] mem_b;
	reg [2:0] saved_idx;
	reg [2:0] exc_idx;
	reg [WIDTH-1:0] wr_val;
	reg [WIDTH-1:0] pc_step;
	reg mem_we;
	reg [4:0] mem_waddr;
	reg [WIDTH-1:0] mem_wdata;
	reg pc_rd_a;
	reg pc_rd_b;
	reg [2:0] view_idx;
	reg [WIDTH-1:0] saved_nxt;
	integer k;

	assign mode = cur_sw_r[`BMRF_SW_MODE_HI:`BMRF_SW_MODE_LO];

	// ****************************************************************
	// Bank index of saved status word per mode
	// ****************************************************************
	function [2:0] saved_of;
		input [4:0] m;
		begin
			case (m)
				`BMRF_MODE_FAST: saved_of = `BMRF_SAVED_FAST;
				`BMRF_MODE_IRQ: saved_of = `BMRF_SAVED_IRQ;
				`BMRF_MODE_SUPV: saved_of = `BMRF_SAVED_SUPV;
				`BMRF_MODE_ABORT: saved_of = `BMRF_SAVED_ABORT;
				`BMRF_MODE_UNDEF: saved_of = `BMRF_SAVED_UNDEF;
				default: saved_of = `BMRF_SAVED_NONE;
			endcase
		end
	endfunction

	// (RL7) Seven legal modes
	function mode_ok;
		input [4:0] m;
		begin
			case (m)
				`BMRF_MODE_USER, `BMRF_MODE_FAST, `BMRF_MODE_IRQ, `BMRF_MODE_SUPV,
				`BMRF_MODE_ABORT, `BMRF_MODE_UNDEF, `BMRF_MODE_SYS: mode_ok = 1'b1;
				default: mode_ok = 1'b0;
			endcase
		end
	endfunction

	// ****************************************************************
	// Mode mapping of each port
	// ****************************************************************
	// (RL2) Sixteen numbers per mode
	// (RL16) Same cycle mapping
	bmrf_bank_map u_map_a (
		.mode(mode),
		.regnum(rd_num_a),
		.phys(phys_a)
	);

	bmrf_bank_map u_map_b (
		.mode(mode),
		.regnum(rd_num_b),
		.phys(phys_b)
	);

	bmrf_bank_map u_map_w (
		.mode(mode),
		.regnum(wr_num),
		.phys(phys_w)
	);

	// (RL6) Link of current mode
	bmrf_bank_map u_map_lr (
		.mode(mode),
		.regnum(4'he),
		.phys(phys_lr)
	);

	// (RL13) Link of the entered mode
	bmrf_bank_map u_map_lrx (
		.mode(exc_mode),
		.regnum(4'he),
		.phys(phys_lr_exc)
	);

	// ****************************************************************
	// Write data sizing and write port select
	// ****************************************************************
	always @* begin
		// (RL10) Zero-extend narrow transfers
		case (wr_size)
			`BMRF_SIZE_BYTE: wr_val = {{(WIDTH-8){1'b0}}, wr_data[7:0]};
			`BMRF_SIZE_HALF: wr_val = {{(WIDTH-16){1'b0}}, wr_data[15:0]};
			default: wr_val = wr_data;
		endcase
		// (RL9) Compact state steps the counter by two
		if (cur_sw_r[`BMRF_SW_STATE_BIT]) begin
			pc_step = {{(WIDTH-3){1'b0}}, 3'h2};
		end else begin
			pc_step = {{(WIDTH-3){1'b0}}, 3'h4};
		end
		exc_idx = saved_of(exc_mode);
		mem_we = 1'b0;
		mem_waddr = phys_w;
		mem_wdata = wr_val;
		if (exc_en && mode_ok(exc_mode) && exc_idx != `BMRF_SAVED_NONE) begin
			// (RL13) Return address into entered mode link
			mem_we = 1'b1;
			mem_waddr = phys_lr_exc;
			mem_wdata = exc_return;
		end else if (link_en) begin
			// (RL6) Return address into current link
			mem_we = 1'b1;
			mem_waddr = phys_lr;
			mem_wdata = pc_r + pc_step;
		end else if (wr_en && wr_num != 4'hf) begin
			// (RL16) Only active copy written
			mem_we = 1'b1;
		end
	end

	// (RL1) Thirty-one general copies
	bmrf_phys_mem #(
		.WIDTH(WIDTH),
		.DEPTH(`BMRF_NUM_PHYS),
		.AW(5)
	) u_mem (
		.clk(clk),
		.rst(rst),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr_a(phys_a),
		.raddr_b(phys_b),
		.rdata_a(mem_a),
		.rdata_b(mem_b)
	);

	// ****************************************************************
	// Program counter and status words
	// ****************************************************************
	always @* begin
		saved_idx = saved_of(mode);
		pc_nxt = pc_r;
		cur_sw_nxt = cur_sw_r;
		if (exc_en && mode_ok(exc_mode) && exc_idx != `BMRF_SAVED_NONE) begin
			// (RL8) Exception entry switches mode
			pc_nxt = exc_vector;
			cur_sw_nxt = cur_sw_r;
			cur_sw_nxt[`BMRF_SW_MODE_HI:`BMRF_SW_MODE_LO] = exc_mode;
			cur_sw_nxt[`BMRF_SW_IRQ_DIS_BIT] = 1'b1;
			cur_sw_nxt[`BMRF_SW_STATE_BIT] = 1'b0;
			if (exc_mode == `BMRF_MODE_FAST) begin
				cur_sw_nxt[`BMRF_SW_FIQ_DIS_BIT] = 1'b1;
			end
		end else begin
			// (RL5) Counter written as register fifteen
			if (wr_en && wr_num == 4'hf) begin
				pc_nxt = wr_val;
			end else if (pc_load_en) begin
				pc_nxt = pc_load;
			end else if (pc_adv) begin
				pc_nxt = pc_r + pc_step;
			end
			if (ret_restore && saved_idx != `BMRF_SAVED_NONE) begin
				cur_sw_nxt = saved_r[saved_idx];
			end else if (sw_wr_en) begin
				// (RL8) Software mode change, user may touch flags only
				if (mode == `BMRF_MODE_USER) begin
					cur_sw_nxt[WIDTH-1:`BMRF_SW_FLAGS_LO] = sw_wr_data[WIDTH-1:`BMRF_SW_FLAGS_LO];
				end else if (mode_ok(sw_wr_data[`BMRF_SW_MODE_HI:`BMRF_SW_MODE_LO])) begin
					cur_sw_nxt = sw_wr_data;
				end else begin
					cur_sw_nxt[WIDTH-1:`BMRF_SW_FLAGS_LO] = sw_wr_data[WIDTH-1:`BMRF_SW_FLAGS_LO];
				end
			end
		end
		// (RL15) Saved word of the mode in force after this edge
		view_idx = saved_of(cur_sw_nxt[`BMRF_SW_MODE_HI:`BMRF_SW_MODE_LO]);
		if (view_idx == `BMRF_SAVED_NONE) begin
			saved_nxt = {WIDTH{1'b0}};
		end else if (exc_en && mode_ok(exc_mode) && exc_idx != `BMRF_SAVED_NONE) begin
			saved_nxt = cur_sw_r;
		end else if (saved_wr_en && view_idx == saved_idx) begin
			// Show a write of this edge at once, not one cycle late
			saved_nxt = saved_wr_data;
		end else begin
			saved_nxt = saved_r[view_idx];
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			pc_r <= `BMRF_PC_RESET;
			cur_sw_r <= `BMRF_SW_RESET;
			for (k = 0; k < 5; k = k + 1) begin
				saved_r[k] <= {WIDTH{1'b0}};
			end
		end else begin
			pc_r <= pc_nxt;
			cur_sw_r <= cur_sw_nxt;
			if (exc_en && mode_ok(exc_mode) && exc_idx != `BMRF_SAVED_NONE) begin
				// (RL15) Capture interrupted status word
				saved_r[exc_idx] <= cur_sw_r;
			end else if (saved_wr_en && saved_idx != `BMRF_SAVED_NONE) begin
				saved_r[saved_idx] <= saved_wr_data;
			end
		end
	end

	// ****************************************************************
	// Registered outputs
	// ****************************************************************
	always @(posedge clk) begin
		if (rst) begin
			pc_rd_a <= 1'b0;
			pc_rd_b <= 1'b0;
			current_status_word <= `BMRF_SW_RESET;
			saved_status_word <= {WIDTH{1'b0}};
			mode_out <= `BMRF_MODE_SUPV;
			privileged <= 1'b1;
			mode_bad <= 1'b0;
			pc_out <= `BMRF_PC_RESET;
		end else begin
			pc_rd_a <= (rd_num_a == 4'hf);
			pc_rd_b <= (rd_num_b == 4'hf);
			current_status_word <= cur_sw_nxt;
			saved_status_word <= saved_nxt;
			mode_out <= cur_sw_nxt[4:0];
			// (RL8) Every mode but user is privileged
			privileged <= (cur_sw_nxt[4:0] != `BMRF_MODE_USER);
			mode_bad <= ~mode_ok(cur_sw_nxt[4:0]);
			pc_out <= pc_nxt;
		end
	end

	// (RL5) Counter readable on both ports
	always @* begin
		rd_data_a = pc_rd_a ? pc_out : mem_a;
		rd_data_b = pc_rd_b ? pc_out : mem_b;
	end
endmodule // bmrf_top

`default_nettype wire

// >>> bench/bmrf_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "bmrf_defs.vh"

module bmrf_props #(
	parameter WIDTH = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] rd_num_a,
	input wire logic [3:0] rd_num_b,
	input wire logic wr_en,
	input wire logic [3:0] wr_num,
	input wire logic pc_adv,
	input wire logic pc_load_en,
	input wire logic exc_en,
	input wire logic [4:0] exc_mode,
	input wire logic [WIDTH-1:0] exc_vector,
	input wire logic sw_wr_en,
	input wire logic ret_restore,
	input wire logic [WIDTH-1:0] rd_data_a,
	input wire logic [WIDTH-1:0] rd_data_b,
	input wire logic [WIDTH-1:0] pc_out,
	input wire logic [WIDTH-1:0] current_status_word,
	input wire logic [WIDTH-1:0] saved_status_word,
	input wire logic [4:0] mode_out,
	input wire logic privileged
);
	logic [WIDTH-1:0] step;
	assign step = current_status_word[5] ? 'h2 : 'h4;
	function automatic logic is_exc(input logic [4:0] m);
		return m inside {`BMRF_MODE_FAST, `BMRF_MODE_IRQ, `BMRF_MODE_SUPV, `BMRF_MODE_ABORT, `BMRF_MODE_UNDEF};
	endfunction
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	exc_mode_a: assert property (exc_en && is_exc(exc_mode) |=> mode_out == $past(exc_mode))
		else $error("exception entry mode wrong");
	exc_saved_a: assert property (exc_en && is_exc(exc_mode) |=> saved_status_word == $past(current_status_word))
		else $error("saved status not captured");
	exc_pc_a: assert property (exc_en && is_exc(exc_mode) |=> pc_out == $past(exc_vector))
		else $error("exception vector not loaded");
	exc_ignore_a: assert property (exc_en && !is_exc(exc_mode) && !sw_wr_en && !ret_restore |=> $stable(mode_out))
		else $error("bad exception mode taken");
	pc_step_a: assert property (pc_adv && !exc_en && !pc_load_en && !(wr_en && wr_num == 4'hf)
		|=> pc_out == $past(pc_out) + $past(step))
		else $error("pc step wrong");
	pc_read_a: assert property (rd_num_a == 4'hf |=> rd_data_a == pc_out)
		else $error("pc not readable");
	priv_mode_a: assert property (privileged == (mode_out != `BMRF_MODE_USER))
		else $error("privilege flag wrong");
	user_ctrl_a: assert property (sw_wr_en && mode_out == `BMRF_MODE_USER && !exc_en && !ret_restore
		|=> current_status_word[27:0] == $past(current_status_word[27:0]))
		else $error("user changed control bits");
	ret_restore_a: assert property (ret_restore && !exc_en && is_exc(mode_out)
		|=> current_status_word == $past(saved_status_word))
		else $error("status not restored");
	read_pair_a: assert property (rd_num_a == rd_num_b |=> rd_data_a == rd_data_b)
		else $error("read ports disagree");
endmodule // bmrf_props

bind bmrf_top bmrf_props #(.WIDTH(WIDTH)) bmrf_props_i (.clk, .rst, .rd_num_a, .rd_num_b, .wr_en, .wr_num,
	.pc_adv, .pc_load_en, .exc_en, .exc_mode, .exc_vector, .sw_wr_en, .ret_restore, .rd_data_a, .rd_data_b,
	.pc_out, .current_status_word, .saved_status_word, .mode_out, .privileged);

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bmrf_defs.vh"

module tb_top;
	logic clk = 0, rst = 1;
	logic [3:0] rd_num_a = 0, rd_num_b = 0, wr_num = 0;
	logic wr_en = 0, link_en = 0, pc_adv = 0, pc_load_en = 0, exc_en = 0;
	logic sw_wr_en = 0, saved_wr_en = 0, ret_restore = 0;
	logic [1:0] wr_size = 2;
	logic [4:0] exc_mode = 0;
	logic [31:0] wr_data = 0, pc_load = 0, exc_vector = 0, exc_return = 0, sw_wr_data = 0, saved_wr_data = 0;
	wire [31:0] rd_data_a, rd_data_b, pc_out, current_status_word, saved_status_word;
	wire [4:0] mode_out;
	wire privileged, mode_bad;
	int errors = 0, n_tests = 0, cycles = 0;
	logic [4:0] modes [6] = '{`BMRF_MODE_SYS, `BMRF_MODE_FAST, `BMRF_MODE_IRQ, `BMRF_MODE_SUPV,
		`BMRF_MODE_ABORT, `BMRF_MODE_UNDEF};

	bmrf_top bmrf_top_i (.clk, .rst, .rd_num_a, .rd_num_b, .wr_en, .wr_num, .wr_data, .wr_size, .link_en,
		.pc_adv, .pc_load, .pc_load_en, .exc_en, .exc_mode, .exc_vector, .exc_return, .sw_wr_en, .sw_wr_data,
		.saved_wr_en, .saved_wr_data, .ret_restore, .rd_data_a, .rd_data_b, .pc_out, .current_status_word,
		.saved_status_word, .mode_out, .privileged, .mode_bad);

	always #2.5 clk = ~clk;

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			end_of_test();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tick;
		@(negedge clk);
	endtask

	task automatic wr(input logic [3:0] n, input logic [31:0] d);
		wr_en = 1;
		wr_num = n;
		wr_data = d;
		tick();
		wr_en = 0;
	endtask

	task automatic rd(input logic [3:0] n, input logic [31:0] exp);
		rd_num_a = n;
		rd_num_b = n;
		tick();
		chk("rd_data_a", exp, rd_data_a);
		chk("rd_data_b", exp, rd_data_b);
	endtask

	task automatic setsw(input logic [31:0] d);
		sw_wr_en = 1;
		sw_wr_data = d;
		tick();
		sw_wr_en = 0;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_banks;
		for (int i = 0; i < 6; i++) begin
			setsw(32'hc0 | modes[i]);
			wr(13, 32'h100 + i);
			wr(14, 32'h200 + i);
			wr(9, 32'h300 + i);
			wr(3, 32'h400 + i);
		end
		for (int i = 0; i < 6; i++) begin
			setsw(32'hc0 | modes[i]);
			rd(13, 32'h100 + i);
			rd(14, 32'h200 + i);
			rd(9, (i == 1) ? 32'h301 : 32'h305);
			rd(3, 32'h405);
		end
	endtask

	task automatic t_size;
		for (int s = 0; s < 3; s++) begin
			wr_size = s[1:0];
			wr(2, 32'haabbccdd);
			rd(2, (s == 0) ? 32'hdd : (s == 1) ? 32'hccdd : 32'haabbccdd);
		end
	endtask

	task automatic t_link;
		for (int st = 0; st < 2; st++) begin
			setsw(32'hc0 | (st << 5) | `BMRF_MODE_SUPV);
			pc_load = 32'h200;
			pc_load_en = 1;
			tick();
			pc_load_en = 0;
			link_en = 1;
			tick();
			link_en = 0;
			rd(14, st ? 32'h202 : 32'h204);
			pc_adv = 1;
			tick();
			pc_adv = 0;
			chk("pc_out", st ? 32'h202 : 32'h204, pc_out);
		end
	endtask

	task automatic t_exc;
		for (int i = 1; i < 6; i++) begin
			setsw(32'h500000df);
			exc_mode = modes[i];
			exc_vector = 32'h1000 + 8 * i;
			exc_return = 32'h2000 + i;
			exc_en = 1;
			tick();
			exc_en = 0;
			chk("mode_out", {27'h0, modes[i]}, {27'h0, mode_out});
			chk("saved_status_word", 32'h500000df, saved_status_word);
			chk("pc_out", 32'h1000 + 8 * i, pc_out);
			rd(14, 32'h2000 + i);
			ret_restore = 1;
			tick();
			ret_restore = 0;
			chk("current_status_word", 32'h500000df, current_status_word);
		end
		exc_mode = `BMRF_MODE_USER;
		exc_en = 1;
		tick();
		exc_en = 0;
		chk("mode_out", 32'h1f, {27'h0, mode_out});
	endtask

	task automatic t_user;
		setsw(32'hd0);
		chk("privileged", 32'h0, {31'h0, privileged});
		rd(13, 32'h100);
		setsw(32'hf000001f);
		chk("current_status_word", 32'hf00000d0, current_status_word);
	endtask

	task automatic t_saved;
		exc_mode = `BMRF_MODE_SUPV;
		exc_vector = 32'h3000;
		exc_en = 1;
		tick();
		exc_en = 0;
		chk("privileged", 32'h1, {31'h0, privileged});
		saved_wr_data = 32'h600000c5;
		saved_wr_en = 1;
		tick();
		saved_wr_en = 0;
		chk("saved_status_word", 32'h600000c5, saved_status_word);
		wr(15, 32'h400);
		chk("pc_out", 32'h400, pc_out);
		rd(15, 32'h400);
		ret_restore = 1;
		tick();
		ret_restore = 0;
		chk("current_status_word", 32'h600000c5, current_status_word);
		chk("mode_bad", 32'h1, {31'h0, mode_bad});
		setsw(32'hdf);
		chk("mode_bad", 32'h0, {31'h0, mode_bad});
		chk("current_status_word", 32'hdf, current_status_word);
	endtask

	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk) rst = 0;
		chk("pc_out", 32'h0, pc_out);
		chk("current_status_word", 32'hd3, current_status_word);
		chk("privileged", 32'h1, {31'h0, privileged});
		tick();
		t_banks();
		t_size();
		t_link();
		t_exc();
		t_user();
		t_saved();
		end_of_test();
	end
endmodule // tb_top

`default_nettype wire
